// [logic/gdm_map.vh]
// Constants for the gas detector mode controller.
`ifndef GDM_MAP_VH
`define GDM_MAP_VH
// Register offsets (byte addresses, word aligned).
`define GDM_ADDR_W          4
`define GDM_OFF_CTRL        4'h0
`define GDM_OFF_SETPT       4'h4
`define GDM_OFF_CONC        4'h8
`define GDM_OFF_STAT        4'hC
// Control register fields.
`define GDM_CTRL_LATCH_BIT  0
`define GDM_CTRL_FAULT_BIT  1
`define GDM_CTRL_PWRF_BIT   2
`define GDM_CTRL_RRST_BIT   3
`define GDM_CTRL_RREN_BIT   4
`define GDM_CTRL_CALX_BIT   5
`define GDM_CTRL_F0MA_BIT   6
`define GDM_CTRL_RESET      7'h00
// Setpoint register reset values (percent of range).
`define GDM_LOW_SP_RESET    8'h14
`define GDM_HIGH_SP_RESET   8'h32
// Mode codes.
`define GDM_MODE_PROT       3'h0
`define GDM_MODE_LOW        3'h1
`define GDM_MODE_HIGH       3'h2
`define GDM_MODE_FAULT      3'h3
`define GDM_MODE_CAL        3'h4
// Display brightness codes.
`define GDM_BRT_DIM         2'h0
`define GDM_BRT_HALF        2'h1
`define GDM_BRT_FULL        2'h2
// Loop current codes in tenths of a milliamp.
`define GDM_LOOP_0MA        8'h00
`define GDM_LOOP_2MA        8'h14
`define GDM_LOOP_4MA        8'h28
`define GDM_LOOP_SPAN       8'hA0
// Times in milliseconds and the clock rate in kHz.
`define GDM_CLK_KHZ         50000
`define GDM_VIEW_MS         1000
`define GDM_SHOW_MS         8000
`define GDM_HOLD_MS         5000
`define GDM_IDLE_MS         5000
`define GDM_DEB_MS          20
`define GDM_TICK_MS         1
`define GDM_FAST_BLINK_MS   125
`define GDM_SLOW_BLINK_MS   2000
`define GDM_SLOW_ON_MS      100
`endif

// [logic/gdm_mode_ctrl.v]
// Mode controller for a combustible gas detector with an Avalon-MM register slave.
`timescale 1ns/1ps
`include "gdm_map.vh"

// Behaviour
// - Short key press then release: full brightness, show setpoints about eight seconds.
// - Five seconds held shows hold message; five more arms calibration, entered on release.
// - Key sensed at activation position raises display brightness immediately.
// - Exactly five modes: protection, low, high, fault, calibration.
// - Protection: backlight dimmed, green power LED lit with occasional blink.
// - Protection: relays in normal state, loop output at 4.0 mA.
// - Key activation in protection: full brightness, show low then high setpoints.
// - Gas below low setpoint: show concentration at half brightness.
// - Gas above zero raises loop current in proportion to concentration.
// - At low setpoint: flash screen, flash low LED, energise low relay.
// - Non-latching low: below setpoint stop flashing, stay full bright until zero.
// - Latching low keeps flashing until a key activation cancels it.
// - Optional remote reset also cancels a latched low alarm.
// - Zero gas with nothing pending: half brightness, back to protection.
// - At high setpoint: flash high LED, energise high relay, low keeps flashing.
// - High alarm always latched until key activation or remote reset.
// - Fault: flash screen with fault message, flash yellow LED unless power failing.
// - Fault: loop output 2.0 mA or 0.0 mA, fault relay changes state.
// - Calibration: loop at 4.0 mA, alarms suppressed, alarm relays off.
// - Calibration held until completed, cancelled or aborted.
// - Display dims after five seconds without user activity.
// - High alarm flashing persists until below high setpoint and reset given.
module gdm_mode_ctrl #(
  parameter DEB_CYC   = (`GDM_DEB_MS * `GDM_CLK_KHZ),
  parameter TICK_CYC  = (`GDM_TICK_MS * `GDM_CLK_KHZ),
  parameter VIEW_MS   = `GDM_VIEW_MS,
  parameter SHOW_MS   = `GDM_SHOW_MS,
  parameter HOLD_MS   = `GDM_HOLD_MS,
  parameter IDLE_MS   = `GDM_IDLE_MS
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        clk_en,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        magnet_key_input,
  input  wire        remote_reset_in,
  output reg  [2:0]  mode_reg,
  output reg  [1:0]  brightness_reg,
  output reg         screen_flash_reg,
  output reg         show_setpoints_reg,
  output reg         show_hold_msg_reg,
  output reg         show_fault_msg_reg,
  output reg         power_led_reg,
  output reg         low_led_reg,
  output reg         high_led_reg,
  output reg         fault_led_reg,
  output reg         low_relay_reg,
  output reg         high_relay_reg,
  output reg         fault_relay_reg,
  output reg  [7:0]  loop_current_reg
);

  localparam [31:0] MS_FAST = `GDM_FAST_BLINK_MS;
  localparam [31:0] MS_SLOW = `GDM_SLOW_BLINK_MS;
  localparam [31:0] MS_SLON = `GDM_SLOW_ON_MS;

  // Key state machine codes.
  localparam [2:0] K_IDLE = 3'h0;
  localparam [2:0] K_PRESS = 3'h1;
  localparam [2:0] K_HOLD = 3'h2;
  localparam [2:0] K_ARMED = 3'h3;
  localparam [2:0] K_SHOW = 3'h4;

  // Software registers, then internal state.
  reg  [6:0]  ctrl_reg;
  reg  [7:0]  low_sp_reg;
  reg  [7:0]  high_sp_reg;
  reg  [7:0]  conc_reg;
  reg         rr_meta_reg;
  reg         rr_sync_reg;
  reg         rr_prev_reg;
  reg         key_meta_reg;
  reg         key_sync_reg;
  reg         key_deb_reg;
  reg  [31:0] deb_cnt_reg;
  reg  [31:0] tick_cnt_reg;
  reg         tick_reg;
  reg  [2:0]  key_st_reg;
  reg  [31:0] key_ms_reg;
  reg  [31:0] idle_ms_reg;
  reg  [31:0] fast_ms_reg;
  reg  [31:0] slow_ms_reg;
  reg         low_latch_reg;
  reg         high_latch_reg;
  reg         gas_seen_reg;
  reg         cal_req_reg;

  wire        wr_hit   = avs_write & ~avs_waitrequest;
  // The tick is gone by the time the view count reaches zero, so the cancel must not wait for it.
  wire        key_act  = (key_st_reg == K_SHOW) & (key_ms_reg == 32'h0);
  wire        rr_edge  = rr_sync_reg & ~rr_prev_reg & ctrl_reg[`GDM_CTRL_RREN_BIT];
  wire        sw_rr    = wr_hit & (avs_address == `GDM_OFF_CTRL) & avs_byteenable[0] &
                         avs_writedata[`GDM_CTRL_RRST_BIT];
  wire        cancel   = key_act | rr_edge | sw_rr;
  wire        in_cal   = cal_req_reg;
  wire        fault_on = ctrl_reg[`GDM_CTRL_FAULT_BIT] | ctrl_reg[`GDM_CTRL_PWRF_BIT];
  wire        at_low   = (conc_reg >= low_sp_reg);
  wire        at_high  = (conc_reg >= high_sp_reg);
  wire        fast_blk = (fast_ms_reg < (MS_FAST >> 1));
  wire        slow_blk = (slow_ms_reg >= MS_SLON);
  wire [15:0] scaled   = conc_reg * `GDM_LOOP_SPAN;

  // Avalon slave: one wait cycle per access, then answer; unmapped reads give zero.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      ctrl_reg        <= `GDM_CTRL_RESET;
      low_sp_reg      <= `GDM_LOW_SP_RESET;
      high_sp_reg     <= `GDM_HIGH_SP_RESET;
      conc_reg        <= 8'h00;
    end else if (clk_en) begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      // The remote reset bit is a pulse and self clears; calibration exit likewise.
      ctrl_reg[`GDM_CTRL_RRST_BIT] <= 1'b0;
      ctrl_reg[`GDM_CTRL_CALX_BIT] <= 1'b0;
      if (wr_hit && avs_byteenable[0]) begin
        case (avs_address)
          `GDM_OFF_CTRL:  ctrl_reg <= avs_writedata[6:0];
          `GDM_OFF_SETPT: begin
            low_sp_reg  <= avs_writedata[7:0];
          end
          `GDM_OFF_CONC:  conc_reg <= avs_writedata[7:0];
          default: ;
        endcase
      end
      if (wr_hit && avs_byteenable[1] && avs_address == `GDM_OFF_SETPT) begin
        high_sp_reg <= avs_writedata[15:8];
      end
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          `GDM_OFF_CTRL:  avs_readdata <= {25'h0, ctrl_reg};
          `GDM_OFF_SETPT: avs_readdata <= {16'h0, high_sp_reg, low_sp_reg};
          `GDM_OFF_CONC:  avs_readdata <= {24'h0, conc_reg};
          `GDM_OFF_STAT:  avs_readdata <= {20'h0, low_latch_reg, high_latch_reg, key_deb_reg,
                                           brightness_reg, screen_flash_reg, key_st_reg, mode_reg};
          default:        avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // Input synchronisers for the key and the remote reset pin.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_meta_reg <= 1'b0;
      key_sync_reg <= 1'b0;
      rr_meta_reg  <= 1'b0;
      rr_sync_reg  <= 1'b0;
      rr_prev_reg  <= 1'b0;
    end else if (clk_en) begin
      key_meta_reg <= magnet_key_input;
      key_sync_reg <= key_meta_reg;
      rr_meta_reg  <= remote_reset_in;
      rr_sync_reg  <= rr_meta_reg;
      rr_prev_reg  <= rr_sync_reg;
    end
  end

  // Debounce key level.
  // The filtered level only follows after the input has been stable for DEB_CYC cycles.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_deb_reg <= 1'b0;
      deb_cnt_reg <= 32'h0;
    end else if (clk_en) begin
      if (key_sync_reg == key_deb_reg) begin
        deb_cnt_reg <= 32'h0;
      end else if (deb_cnt_reg >= DEB_CYC - 1) begin
        key_deb_reg <= key_sync_reg;
        deb_cnt_reg <= 32'h0;
      end else begin
        deb_cnt_reg <= deb_cnt_reg + 32'h1;
      end
    end
  end

  // Millisecond tick shared by the key, idle and blink timers; the debounce counter counts clocks.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 32'h0;
      tick_reg     <= 1'b0;
    end else if (clk_en) begin
      tick_reg <= (tick_cnt_reg >= TICK_CYC - 1);
      if (tick_cnt_reg >= TICK_CYC - 1) begin
        tick_cnt_reg <= 32'h0;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
      end
    end
  end

  // Blink phase counters for fast alarm flashing and the slow power blink.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_ms_reg <= 32'h0;
      slow_ms_reg <= 32'h0;
    end else if (clk_en && tick_reg) begin
      fast_ms_reg <= (fast_ms_reg >= MS_FAST - 1) ? 32'h0 : fast_ms_reg + 32'h1;
      slow_ms_reg <= (slow_ms_reg >= MS_SLOW - 1) ? 32'h0 : slow_ms_reg + 32'h1;
    end
  end

  // Key sequencer: press, long hold, armed for calibration, or showing setpoints.
  // Release ends hold.
  // Actions fire on release, never while held, so a long hold cannot also view setpoints.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_st_reg  <= K_IDLE;
      key_ms_reg  <= 32'h0;
      cal_req_reg <= 1'b0;
    end else if (clk_en) begin
      if (cal_req_reg && ctrl_reg[`GDM_CTRL_CALX_BIT]) begin
        cal_req_reg <= 1'b0;
      end
      case (key_st_reg)
        K_IDLE: begin
          key_ms_reg <= 32'h0;
          if (key_deb_reg && !cal_req_reg) begin
            key_st_reg <= K_PRESS;
          end
        end
        K_PRESS: begin
          if (tick_reg) begin
            key_ms_reg <= key_ms_reg + 32'h1;
          end
          if (!key_deb_reg) begin
            key_st_reg <= K_SHOW;
            key_ms_reg <= SHOW_MS;
          end else if (key_ms_reg >= HOLD_MS) begin
            key_st_reg <= K_HOLD;
            key_ms_reg <= 32'h0;
          end
        end
        K_HOLD: begin
          if (tick_reg) begin
            key_ms_reg <= key_ms_reg + 32'h1;
          end
          if (!key_deb_reg) begin
            key_st_reg <= K_IDLE;
          end else if (key_ms_reg >= HOLD_MS) begin
            key_st_reg <= K_ARMED;
          end
        end
        K_ARMED: begin
          if (!key_deb_reg) begin
            key_st_reg  <= K_IDLE;
            cal_req_reg <= 1'b1;
          end
        end
        K_SHOW: begin
          if (key_ms_reg == 32'h0) begin
            key_st_reg <= K_IDLE;
          end else if (tick_reg) begin
            key_ms_reg <= key_ms_reg - 32'h1;
          end
        end
        default: key_st_reg <= K_IDLE;
      endcase
    end
  end

  // Alarm latches; a new trip wins over a cancel in the same cycle.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_latch_reg  <= 1'b0;
      high_latch_reg <= 1'b0;
      gas_seen_reg   <= 1'b0;
    end else if (clk_en) begin
      if (in_cal) begin
        low_latch_reg  <= 1'b0;
        high_latch_reg <= 1'b0;
      end else begin
        // Latched low cleared by key or remote.
        if (at_low) begin
          low_latch_reg <= 1'b1;
        end else if (cancel || !ctrl_reg[`GDM_CTRL_LATCH_BIT]) begin
          low_latch_reg <= 1'b0;
        end
        // High only cleared below setpoint with a reset.
        if (at_high) begin
          high_latch_reg <= 1'b1;
        end else if (cancel) begin
          high_latch_reg <= 1'b0;
        end
      end
      if (conc_reg == 8'h00) begin
        gas_seen_reg <= 1'b0;
      end else if (at_low) begin
        gas_seen_reg <= 1'b1;
      end
    end
  end

  // Inactivity timer for energy saving.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_ms_reg <= 32'h0;
    end else if (clk_en) begin
      if (key_deb_reg || key_st_reg != K_IDLE) begin
        idle_ms_reg <= 32'h0;
      end else if (tick_reg && idle_ms_reg < IDLE_MS) begin
        idle_ms_reg <= idle_ms_reg + 32'h1;
      end
    end
  end

  // Output stage: mode priority is calibration, fault, high, low, then protection.
  // Five mode codes.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg           <= `GDM_MODE_PROT;
      brightness_reg     <= `GDM_BRT_DIM;
      screen_flash_reg   <= 1'b0;
      show_setpoints_reg <= 1'b0;
      show_hold_msg_reg  <= 1'b0;
      show_fault_msg_reg <= 1'b0;
      power_led_reg      <= 1'b0;
      low_led_reg        <= 1'b0;
      high_led_reg       <= 1'b0;
      fault_led_reg      <= 1'b0;
      low_relay_reg      <= 1'b0;
      high_relay_reg     <= 1'b0;
      fault_relay_reg    <= 1'b0;
      loop_current_reg   <= `GDM_LOOP_4MA;
    end else if (clk_en) begin
      show_setpoints_reg <= (key_st_reg == K_SHOW);
      show_hold_msg_reg  <= (key_st_reg == K_HOLD) | (key_st_reg == K_ARMED);
      power_led_reg      <= slow_blk;
      show_fault_msg_reg <= 1'b0;
      fault_led_reg      <= 1'b0;
      fault_relay_reg    <= fault_on & ~in_cal;
      if (in_cal) begin
        mode_reg         <= `GDM_MODE_CAL;
        screen_flash_reg <= 1'b0;
        low_led_reg      <= 1'b0;
        high_led_reg     <= 1'b0;
        low_relay_reg    <= 1'b0;
        high_relay_reg   <= 1'b0;
        loop_current_reg <= `GDM_LOOP_4MA;
        brightness_reg   <= `GDM_BRT_FULL;
      end else if (fault_on) begin
        mode_reg           <= `GDM_MODE_FAULT;
        screen_flash_reg   <= fast_blk;
        show_fault_msg_reg <= fast_blk;
        fault_led_reg      <= fast_blk & ~ctrl_reg[`GDM_CTRL_PWRF_BIT];
        loop_current_reg   <= ctrl_reg[`GDM_CTRL_F0MA_BIT] ? `GDM_LOOP_0MA : `GDM_LOOP_2MA;
        low_led_reg        <= 1'b0;
        high_led_reg       <= 1'b0;
        low_relay_reg      <= low_latch_reg;
        high_relay_reg     <= high_latch_reg;
        brightness_reg     <= `GDM_BRT_FULL;
      end else begin
        mode_reg <= high_latch_reg ? `GDM_MODE_HIGH :
                    low_latch_reg  ? `GDM_MODE_LOW  : `GDM_MODE_PROT;
        screen_flash_reg <= (low_latch_reg | high_latch_reg) & fast_blk;
        low_led_reg      <= (low_latch_reg | high_latch_reg) & fast_blk;
        high_led_reg     <= high_latch_reg & fast_blk;
        low_relay_reg    <= low_latch_reg | high_latch_reg;
        high_relay_reg   <= high_latch_reg;
        // Loop current 4 mA plus concentration share.
        loop_current_reg <= `GDM_LOOP_4MA + scaled[14:7];
        // Key or alarm forces full; idle dims.
        if (key_deb_reg || key_st_reg != K_IDLE || low_latch_reg || high_latch_reg || gas_seen_reg) begin
          brightness_reg <= `GDM_BRT_FULL;
        end else if (conc_reg != 8'h00) begin
          brightness_reg <= `GDM_BRT_HALF;
        end else if (idle_ms_reg >= IDLE_MS) begin
          brightness_reg <= `GDM_BRT_DIM;
        end else begin
          brightness_reg <= `GDM_BRT_HALF;
        end
      end
    end
  end

endmodule

// [test/gdm_mode_monitor.sv]
// Port-level assertions for the gas detector mode controller.
`timescale 1ns/1ps
`include "gdm_map.vh"
module gdm_mode_monitor (
  input wire       sys_clk,
  input wire       rst_n,
  input wire       avs_read,
  input wire       avs_write,
  input wire       avs_waitrequest,
  input wire [2:0] mode_reg,
  input wire [1:0] brightness_reg,
  input wire       show_setpoints_reg,
  input wire       low_relay_reg,
  input wire       high_relay_reg,
  input wire       fault_relay_reg,
  input wire [7:0] loop_current_reg
);
  // All checks share the one clock domain and its reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_bus_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not low one cycle after a request");
  a_bus_ack_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_mode_code_legal: assert property (mode_reg <= `GDM_MODE_CAL)
    else $error("mode code outside the five modes");
  a_prot_relays_idle: assert property (mode_reg == `GDM_MODE_PROT && $past(mode_reg) == `GDM_MODE_PROT
    |-> !low_relay_reg && !high_relay_reg && !fault_relay_reg) else $error("relay active in protection");
  a_cal_outputs_quiet: assert property (mode_reg == `GDM_MODE_CAL && $past(mode_reg) == `GDM_MODE_CAL
    |-> loop_current_reg == `GDM_LOOP_4MA && !low_relay_reg && !high_relay_reg)
    else $error("calibration loop or relays wrong");
  a_fault_loop_low: assert property (mode_reg == `GDM_MODE_FAULT && $past(mode_reg) == `GDM_MODE_FAULT
    |-> fault_relay_reg && (loop_current_reg == `GDM_LOOP_2MA || loop_current_reg == `GDM_LOOP_0MA))
    else $error("fault loop or relay wrong");
  a_cal_exit_cause: assert property ($past(mode_reg) == `GDM_MODE_CAL && mode_reg != `GDM_MODE_CAL
    |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3)) else $error("calibration left unasked");
  a_low_relay_cause: assert property ($rose(low_relay_reg)
    |-> ##[0:2] (mode_reg == `GDM_MODE_LOW || mode_reg == `GDM_MODE_HIGH)) else $error("low relay without alarm");
  a_high_relay_cause: assert property ($rose(high_relay_reg) |-> ##[0:2] mode_reg == `GDM_MODE_HIGH)
    else $error("high relay without high alarm");
  a_show_full_bright: assert property ($rose(show_setpoints_reg) |-> ##[0:2] brightness_reg == `GDM_BRT_FULL)
    else $error("setpoint view not at full brightness");
endmodule

// [test/gdm_field_model.sv]
// Field side model: magnet key fob with contact bounce and the remote reset line.
`timescale 1ns/1ps
module gdm_field_model (
  input  wire sys_clk,
  output reg  magnet_key_input,
  output reg  remote_reset_in
);
  // Both lines rest low; nothing is applied at power-up.
  initial begin
    magnet_key_input = 1'b0;
    remote_reset_in  = 1'b0;
  end
  // bouncy key contact
  // The fob chatters for a few clocks before it settles, so a short count would misfire.
  task key_hold(input integer cyc);
    integer i;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        @(posedge sys_clk);
        magnet_key_input <= ~i[0];
      end
      repeat (cyc) @(posedge sys_clk);
      magnet_key_input <= 1'b0;
    end
  endtask
  task remote_pulse;
    begin
      @(posedge sys_clk);
      remote_reset_in <= 1'b1;
      repeat (8) @(posedge sys_clk);
      remote_reset_in <= 1'b0;
    end
  endtask
endmodule

// [test/gas_detector_mode_controller_tb.sv]
// Self-checking bench for the gas detector mode controller.
`timescale 1ns/1ps
`include "gdm_map.vh"
module gas_detector_mode_controller_tb;
  reg         sys_clk, rst_n, clk_en, avs_read, avs_write;
  reg  [3:0]  avs_address, avs_byteenable;
  reg  [31:0] avs_writedata, rd;
  wire [31:0] avs_readdata;
  wire [2:0]  mode_reg;
  wire [1:0]  brightness_reg;
  wire [7:0]  loop_current_reg;
  wire        avs_waitrequest, magnet_key_input, remote_reset_in, screen_flash_reg, show_setpoints_reg;
  wire        show_hold_msg_reg, show_fault_msg_reg, power_led_reg, low_led_reg, high_led_reg;
  wire        fault_led_reg, low_relay_reg, high_relay_reg, fault_relay_reg;
  integer     bad_count, checked, cycles;
  integer     cnt [0:8];

  // Short timing: one millisecond tick is four clocks.
  gdm_mode_ctrl #(.DEB_CYC(3), .TICK_CYC(4), .VIEW_MS(1), .SHOW_MS(8), .HOLD_MS(5), .IDLE_MS(5)) gdm_mode_ctrl_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata,
    .avs_waitrequest, .magnet_key_input(magnet_key_input), .remote_reset_in(remote_reset_in), .mode_reg,
    .brightness_reg,
    .screen_flash_reg, .show_setpoints_reg, .show_hold_msg_reg, .show_fault_msg_reg, .power_led_reg,
    .low_led_reg, .high_led_reg, .fault_led_reg, .low_relay_reg, .high_relay_reg, .fault_relay_reg,
    .loop_current_reg);
  gdm_field_model gdm_field_model_i (.sys_clk, .magnet_key_input, .remote_reset_in);

  // Free-running 50 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // The run needs about 11000 clocks; a hang is cut well after that.
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      bad_count = bad_count + 1;
      finish_test;
    end
  end

  task finish_test;
    begin
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk_val(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_true(input ok);
    begin
      checked = checked + 1;
      if (ok !== 1'b1) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: condition false", $time);
      end
    end
  endtask
  // Avalon-MM transfer: held until the edge that samples waitrequest low.
  task bus_xfer(input wr, input [3:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task conc(input [7:0] c);
    begin
      bus_xfer(1'b1, `GDM_OFF_CONC, {24'h0, c});
      repeat (4) @(negedge sys_clk);
    end
  endtask
  task wait_mode(input [2:0] m);
    integer n;
    begin
      for (n = 0; n < 100 && mode_reg !== m; n = n + 1)
        @(negedge sys_clk);
      repeat (2) @(negedge sys_clk);
      chk_val(mode_reg, m);
    end
  endtask
  // Counts how many cycles each indicator is on over a window.
  task sample(input integer n);
    integer i;
    begin
      for (i = 0; i < 9; i = i + 1)
        cnt[i] = 0;
      repeat (n) begin
        @(negedge sys_clk);
        cnt[0] = cnt[0] + low_led_reg;
        cnt[1] = cnt[1] + high_led_reg;
        cnt[2] = cnt[2] + fault_led_reg;
        cnt[3] = cnt[3] + screen_flash_reg;
        cnt[4] = cnt[4] + show_fault_msg_reg;
        cnt[5] = cnt[5] + show_hold_msg_reg;
        cnt[6] = cnt[6] + (mode_reg == `GDM_MODE_CAL);
        cnt[7] = cnt[7] + power_led_reg;
        cnt[8] = cnt[8] + show_setpoints_reg;
      end
    end
  endtask
  function [31:0] loop_of(input [31:0] c);
    loop_of = `GDM_LOOP_4MA + ((c * `GDM_LOOP_SPAN) >> 7);
  endfunction

  // Main sequence: reset, gas levels, alarms, key use, calibration, fault.
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    bad_count = 0;
    checked = 0;
    cycles = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk_val({mode_reg, low_relay_reg, high_relay_reg, fault_relay_reg}, 32'h0);
    chk_val(loop_current_reg, `GDM_LOOP_4MA);
    bus_xfer(1'b0, `GDM_OFF_SETPT, 32'h0);
    chk_val(rd, {16'h0, `GDM_HIGH_SP_RESET, `GDM_LOW_SP_RESET});
    bus_xfer(1'b0, 4'h2, 32'h0);
    chk_val(rd, 32'h0);
    // Only lane one is enabled, so the low setpoint must keep its value.
    @(posedge sys_clk);
    avs_byteenable <= 4'h2;
    bus_xfer(1'b1, `GDM_OFF_SETPT, 32'h0000_4100);
    avs_byteenable <= 4'hF;
    bus_xfer(1'b0, `GDM_OFF_SETPT, 32'h0);
    chk_val(rd, {16'h0, 8'h41, `GDM_LOW_SP_RESET});
    bus_xfer(1'b1, `GDM_OFF_SETPT, {16'h0, `GDM_HIGH_SP_RESET, `GDM_LOW_SP_RESET});
    conc(8'h0A);
    chk_val(loop_current_reg, loop_of(8'h0A));
    chk_val(brightness_reg, `GDM_BRT_HALF);
    conc(8'h14);
    wait_mode(`GDM_MODE_LOW);
    chk_val({low_relay_reg, brightness_reg}, {1'b1, `GDM_BRT_FULL});
    chk_val(loop_current_reg, loop_of(8'h14));
    sample(300);
    chk_true(cnt[0] > 0 && cnt[0] < 300 && cnt[3] > 0);
    conc(8'h0A);
    sample(300);
    chk_true(low_relay_reg === 1'b0 && cnt[0] == 0 && cnt[3] == 0);
    chk_val(brightness_reg, `GDM_BRT_FULL);
    conc(8'h00);
    wait_mode(`GDM_MODE_PROT);
    chk_true(brightness_reg !== `GDM_BRT_FULL);
    bus_xfer(1'b1, `GDM_OFF_CTRL, 32'h01);
    conc(8'h3C);
    wait_mode(`GDM_MODE_HIGH);
    chk_val({low_relay_reg, high_relay_reg}, 32'h3);
    chk_val(loop_current_reg, loop_of(8'h3C));
    sample(300);
    chk_true(cnt[0] > 0 && cnt[1] > 0);
    bus_xfer(1'b1, `GDM_OFF_CTRL, 32'h09);
    sample(20);
    chk_val(mode_reg, `GDM_MODE_HIGH);
    conc(8'h00);
    sample(300);
    chk_true(mode_reg === `GDM_MODE_HIGH && cnt[1] > 0 && cnt[3] > 0);
    bus_xfer(1'b1, `GDM_OFF_CTRL, 32'h09);
    wait_mode(`GDM_MODE_PROT);
    bus_xfer(1'b1, `GDM_OFF_CTRL, 32'h11);
    conc(8'h14);
    wait_mode(`GDM_MODE_LOW);
    conc(8'h00);
    sample(300);
    chk_true(mode_reg === `GDM_MODE_LOW && cnt[0] > 0 && cnt[3] > 0);
    // A pulse while the clock enable is low must be lost and the blink must stand still.
    @(posedge sys_clk);
    clk_en <= 1'b0;
    gdm_field_model_i.remote_pulse;
    sample(20);
    chk_true(mode_reg === `GDM_MODE_LOW && (cnt[0] == 0 || cnt[0] == 20));
    @(posedge sys_clk);
    clk_en <= 1'b1;
    gdm_field_model_i.remote_pulse;
    wait_mode(`GDM_MODE_PROT);
    sample(8100);
    chk_val(brightness_reg, `GDM_BRT_DIM);
    chk_true(cnt[7] > 7000 && cnt[7] < 8100);
    fork
      gdm_field_model_i.key_hold(18);
      begin
        repeat (16) @(negedge sys_clk);
        chk_val(brightness_reg, `GDM_BRT_FULL);
      end
    join
    sample(60);
    chk_true(cnt[8] >= 28 && cnt[8] <= 36);
    chk_val(mode_reg, `GDM_MODE_PROT);
    conc(8'h14);
    wait_mode(`GDM_MODE_LOW);
    conc(8'h00);
    gdm_field_model_i.key_hold(18);
    wait_mode(`GDM_MODE_PROT);
    fork
      gdm_field_model_i.key_hold(70);
      sample(72);
    join
    chk_true(cnt[5] > 0 && cnt[6] == 0);
    wait_mode(`GDM_MODE_CAL);
    conc(8'h3C);
    sample(20);
    chk_val(mode_reg, `GDM_MODE_CAL);
    chk_val({loop_current_reg, low_relay_reg, high_relay_reg}, {`GDM_LOOP_4MA, 2'b00});
    conc(8'h00);
    bus_xfer(1'b1, `GDM_OFF_CTRL, 32'h20);
    wait_mode(`GDM_MODE_PROT);
    bus_xfer(1'b1, `GDM_OFF_CTRL, 32'h02);
    wait_mode(`GDM_MODE_FAULT);
    chk_val({loop_current_reg, fault_relay_reg}, {`GDM_LOOP_2MA, 1'b1});
    sample(300);
    chk_true(cnt[2] > 0 && cnt[3] > 0 && cnt[4] > 0);
    bus_xfer(1'b1, `GDM_OFF_CTRL, 32'h42);
    sample(4);
    chk_val(loop_current_reg, `GDM_LOOP_0MA);
    bus_xfer(1'b1, `GDM_OFF_CTRL, 32'h06);
    repeat (2) @(negedge sys_clk);
    sample(300);
    chk_true(cnt[2] == 0);
    // Reset in mid-run while in fault: outputs and control return to their reset values.
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk_val({mode_reg, fault_relay_reg, loop_current_reg}, {`GDM_MODE_PROT, 1'b0, `GDM_LOOP_4MA});
    bus_xfer(1'b0, `GDM_OFF_CTRL, 32'h0);
    chk_val(rd, {25'h0, `GDM_CTRL_RESET});
    bus_xfer(1'b1, `GDM_OFF_CTRL, 32'h00);
    wait_mode(`GDM_MODE_PROT);
    chk_val(fault_relay_reg, 1'b0);
    finish_test;
  end
endmodule

bind gdm_mode_ctrl gdm_mode_monitor gdm_mode_monitor_i (
  .sys_clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .mode_reg, .brightness_reg, .show_setpoints_reg,
  .low_relay_reg, .high_relay_reg, .fault_relay_reg, .loop_current_reg);
